/* File: exec_pkg.sv */
/*
 * Constants, opcode patterns and state codes for the pointer and logic
 * operation execution datapath. Assumes a 14-bit instruction word
 * delivered by the decoder, one instruction cycle per clock.
 */
package exec_pkg;

    localparam int DATA_W  = 8;
    localparam int PTR_W   = 16;
    localparam int INSTR_W = 14;
    localparam int FADDR_W = 7;
    localparam int LIT6_W  = 6;
    localparam int STALL_W = 2;

    // Opcode fields
    localparam logic [6:0] OPC7_PTR_ADD = 7'h62;  // 11 0001 0
    localparam logic [5:0] OPC_AND_IMM  = 6'h39;  // 11 1001
    localparam logic [5:0] OPC_ADD_IMM  = 6'h3E;  // 11 1110
    localparam logic [5:0] OPC_AND_REG  = 6'h05;  // 00 0101
    localparam logic [5:0] OPC_ADD_REG  = 6'h07;  // 00 0111
    localparam logic [5:0] OPC_ASR      = 6'h37;  // 11 0111

    // Field positions
    localparam int DEST_BIT    = 7;
    localparam int PTR_SEL_BIT = 6;
    localparam int PTR_MSB     = 15;

    // Reset values
    localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
    localparam logic [PTR_W-1:0]   PTR_RST   = 16'h0000;
    localparam logic [STALL_W-1:0] STALL_RST = 2'h0;

    typedef enum logic [1:0]
    {
        ST_READY = 2'b01,
        ST_STALL = 2'b10
    } exec_state_e;

endpackage : exec_pkg

/* File: byte_adder.sv */
/*
 * Eight-bit adder giving sum, carry out and low-nibble carry.
 * Purely combinational; caller registers the results.
 */
`timescale 1ns/1ps
module byte_adder
    import exec_pkg::*;
(
    input  wire logic [DATA_W-1:0] i_a,
    input  wire logic [DATA_W-1:0] i_b,
    output logic      [DATA_W-1:0] o_sum,
    output logic                   o_carry,
    output logic                   o_nibble
);
    logic [DATA_W:0] sum9;
    logic [4:0]      nib5;

    // Full and nibble sums
    always_comb
    begin
        sum9     = {1'b0, i_a} + {1'b0, i_b};
        nib5     = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
        o_sum    = sum9[DATA_W-1:0];
        o_carry  = sum9[DATA_W];
        o_nibble = nib5[4];
    end
endmodule : byte_adder

/* File: ptr_logic_exec.sv */
/*
 * Execution datapath for pointer add, immediate/register add and AND,
 * and arithmetic right shift, plus extra-cycle stalling.
 * Assumes the decoder presents the file register value with the
 * instruction and honours O_READY; all inputs share I_SYS_CLK.
 */
`timescale 1ns/1ps
module ptr_logic_exec
    import exec_pkg::*;
(
    input  wire logic               I_SYS_CLK,
    input  wire logic               I_RESET_N,
    input  wire logic               I_INSTR_VALID,
    input  wire logic [INSTR_W-1:0] I_INSTR,
    input  wire logic [DATA_W-1:0]  I_FILE_RDATA,
    input  wire logic               I_PROG_CNT_WRITE,
    input  wire logic               I_COND_TRUE,
    input  wire logic               I_INDIRECT,
    input  wire logic               I_IND_SEL,
    output logic                    O_READY,
    output logic [DATA_W-1:0]       O_ACC,
    output logic                    O_FLAG_ZERO,
    output logic                    O_FLAG_CARRY,
    output logic                    O_FLAG_NIBBLE,
    output logic [PTR_W-1:0]        O_PTR0,
    output logic [PTR_W-1:0]        O_PTR1,
    output logic                    O_FILE_WE,
    output logic [FADDR_W-1:0]      O_FILE_ADDR,
    output logic [DATA_W-1:0]       O_FILE_WDATA
);
    exec_state_e        state_reg,   state_next;
    logic [STALL_W-1:0] stall_reg,   stall_next;
    logic               ready_reg,   ready_next;
    logic [DATA_W-1:0]  acc_reg,     acc_next;
    logic               zero_reg,    zero_next;
    logic               carry_reg,   carry_next;
    logic               nibble_reg,  nibble_next;
    logic [PTR_W-1:0]   ptr0_reg,    ptr0_next;
    logic [PTR_W-1:0]   ptr1_reg,    ptr1_next;
    logic               we_reg,      we_next;
    logic [FADDR_W-1:0] addr_reg,    addr_next;
    logic [DATA_W-1:0]  wdata_reg,   wdata_next;

    logic               take;
    logic               is_ptr_add;
    logic               is_and_imm;
    logic               is_add_imm;
    logic               is_and_reg;
    logic               is_add_reg;
    logic               is_asr;
    logic               to_file;
    logic [DATA_W-1:0]  op_b;
    logic [DATA_W-1:0]  add_sum;
    logic               add_carry;
    logic               add_nibble;
    logic [DATA_W-1:0]  result;
    logic [PTR_W-1:0]   ptr_ext;
    logic [PTR_W-1:0]   ptr_cur;
    logic [PTR_W-1:0]   ptr_sum;
    logic               ind_msb;
    logic [STALL_W-1:0] extra;

    // Decode; only taken while ready
    always_comb
    begin
        take       = I_INSTR_VALID && ready_reg;
        is_ptr_add = (I_INSTR[13:7] == OPC7_PTR_ADD);
        is_and_imm = (I_INSTR[13:8] == OPC_AND_IMM);
        is_add_imm = (I_INSTR[13:8] == OPC_ADD_IMM);
        is_and_reg = (I_INSTR[13:8] == OPC_AND_REG);
        is_add_reg = (I_INSTR[13:8] == OPC_ADD_REG);
        is_asr     = (I_INSTR[13:8] == OPC_ASR);
        to_file    = (is_and_reg || is_add_reg || is_asr) && I_INSTR[DEST_BIT];
        op_b       = (is_and_imm || is_add_imm) ? I_INSTR[7:0] : I_FILE_RDATA;
    end

    byte_adder u_add
    (
        .i_a      (acc_reg),
        .i_b      (op_b),
        .o_sum    (add_sum),
        .o_carry  (add_carry),
        .o_nibble (add_nibble)
    );

    // Pointer add with sign extension, wraps at 16 bits
    always_comb
    begin
        ptr_ext = {{(PTR_W-LIT6_W){I_INSTR[LIT6_W-1]}}, I_INSTR[LIT6_W-1:0]};
        ptr_cur = I_INSTR[PTR_SEL_BIT] ? ptr1_reg : ptr0_reg;
        ptr_sum = ptr_cur + ptr_ext;
        ind_msb = I_IND_SEL ? ptr1_reg[PTR_MSB] : ptr0_reg[PTR_MSB];
    end

    // Extra cycles owed by the instruction being taken
    always_comb
    begin
        extra = {1'b0, (I_PROG_CNT_WRITE || I_COND_TRUE)}
              + {1'b0, (I_INDIRECT && ind_msb)};
    end

    // Stall sequencing: idle slots hold off the decoder
    always_comb
    begin
        state_next = state_reg;
        stall_next = stall_reg;
        ready_next = ready_reg;
        unique case (state_reg)
            ST_READY:
            begin
                if (take && (extra != STALL_RST))
                begin
                    state_next = ST_STALL;
                    stall_next = extra;
                    ready_next = 1'b0;
                end
            end
            ST_STALL:
            begin
                stall_next = stall_reg - 2'h1;
                if (stall_reg == 2'h1)
                begin
                    state_next = ST_READY;
                    ready_next = 1'b1;
                end
            end
            default:
            begin
                state_next = ST_READY;
                stall_next = STALL_RST;
                ready_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            state_reg <= ST_READY;
            stall_reg <= STALL_RST;
            ready_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            stall_reg <= stall_next;
            ready_reg <= ready_next;
        end
    end

    // Datapath: result, flags, pointers, file write
    always_comb
    begin
        acc_next    = acc_reg;
        zero_next   = zero_reg;
        carry_next  = carry_reg;
        nibble_next = nibble_reg;
        ptr0_next   = ptr0_reg;
        ptr1_next   = ptr1_reg;
        we_next     = 1'b0;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        result      = acc_reg;
        if (take)
        begin
            if (is_and_imm || is_and_reg)
            begin
                result    = acc_reg & op_b;
                zero_next = (result == ACC_RST);
            end
            else if (is_add_imm || is_add_reg)
            begin
                result      = add_sum;
                carry_next  = add_carry;
                nibble_next = add_nibble;
                zero_next   = (result == ACC_RST);
            end
            else if (is_asr)
            begin
                result     = {I_FILE_RDATA[7], I_FILE_RDATA[7:1]};
                carry_next = I_FILE_RDATA[0];
                zero_next  = (result == ACC_RST);
            end
            else if (is_ptr_add)
            begin
                if (I_INSTR[PTR_SEL_BIT])
                    ptr1_next = ptr_sum;
                else
                    ptr0_next = ptr_sum;
            end
            if (is_and_imm || is_add_imm || is_and_reg || is_add_reg || is_asr)
            begin
                if (to_file)
                begin
                    we_next    = 1'b1;
                    addr_next  = I_INSTR[FADDR_W-1:0];
                    wdata_next = result;
                end
                else
                    acc_next = result;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            acc_reg    <= ACC_RST;
            zero_reg   <= 1'b0;
            carry_reg  <= 1'b0;
            nibble_reg <= 1'b0;
            ptr0_reg   <= PTR_RST;
            ptr1_reg   <= PTR_RST;
            we_reg     <= 1'b0;
            addr_reg   <= 7'h00;
            wdata_reg  <= ACC_RST;
        end
        else
        begin
            acc_reg    <= acc_next;
            zero_reg   <= zero_next;
            carry_reg  <= carry_next;
            nibble_reg <= nibble_next;
            ptr0_reg   <= ptr0_next;
            ptr1_reg   <= ptr1_next;
            we_reg     <= we_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
        end
    end

    // Outputs straight from flops
    assign O_READY       = ready_reg;
    assign O_ACC         = acc_reg;
    assign O_FLAG_ZERO   = zero_reg;
    assign O_FLAG_CARRY  = carry_reg;
    assign O_FLAG_NIBBLE = nibble_reg;
    assign O_PTR0        = ptr0_reg;
    assign O_PTR1        = ptr1_reg;
    assign O_FILE_WE     = we_reg;
    assign O_FILE_ADDR   = addr_reg;
    assign O_FILE_WDATA  = wdata_reg;

    // Checks on the datapath and stall timing
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);

    sequence seq_one_idle;
        !ready_reg ##1 ready_reg;
    endsequence

    sequence seq_two_idle;
        !ready_reg ##1 !ready_reg ##1 ready_reg;
    endsequence

    a_branch_idle: assert property (
        take && (I_PROG_CNT_WRITE || I_COND_TRUE) && !(I_INDIRECT && ind_msb) |=> seq_one_idle)
        else $error("branch did not take exactly one idle slot");

    a_indirect_idle: assert property (
        take && I_INDIRECT && ind_msb && (I_PROG_CNT_WRITE || I_COND_TRUE) |=> seq_two_idle)
        else $error("indirect stretch missing after branch");

    a_ptr_add_wrap: assert property (
        take && is_ptr_add && !I_INSTR[PTR_SEL_BIT]
        |=> ptr0_reg == PTR_W'($past(ptr0_reg) + $past(ptr_ext)) && $stable(ptr1_reg)
            && $stable(zero_reg) && $stable(carry_reg) && $stable(nibble_reg))
        else $error("pointer add result or flags wrong");

    a_ptr_only_add: assert property (
        !(take && is_ptr_add) |=> $stable(ptr0_reg) && $stable(ptr1_reg))
        else $error("pointer changed without pointer add");

    a_and_imm_res: assert property (
        take && is_and_imm |=> acc_reg == $past(acc_reg & I_INSTR[7:0])
            && zero_reg == (acc_reg == ACC_RST) && $stable(carry_reg))
        else $error("AND immediate result wrong");

    a_add_imm_res: assert property (
        take && is_add_imm |=> {carry_reg, acc_reg} ==
            $past({1'b0, acc_reg} + {1'b0, I_INSTR[7:0]})
            && nibble_reg == $past(({1'b0, acc_reg[3:0]} + {1'b0, I_INSTR[3:0]}) > 5'h0F)
            && zero_reg == (acc_reg == ACC_RST))
        else $error("add immediate result wrong");

    a_and_reg_dest: assert property (
        take && is_and_reg && I_INSTR[DEST_BIT] |=> we_reg && $stable(acc_reg)
            && wdata_reg == $past(acc_reg & I_FILE_RDATA)
            ##1 (!we_reg || $past(take && to_file)))
        else $error("AND register file write wrong");

    a_add_reg_acc: assert property (
        take && is_add_reg && !I_INSTR[DEST_BIT] |=> !we_reg
            && {carry_reg, acc_reg} == $past({1'b0, acc_reg} + {1'b0, I_FILE_RDATA}))
        else $error("add register result wrong");

    a_asr_shift: assert property (
        take && is_asr && !I_INSTR[DEST_BIT] |=> carry_reg == $past(I_FILE_RDATA[0])
            && acc_reg == $past({I_FILE_RDATA[7], I_FILE_RDATA[7:1]}))
        else $error("arithmetic shift wrong");

    a_zero_flag: assert property (
        take && is_asr && I_INSTR[DEST_BIT] |=> zero_reg == (wdata_reg == ACC_RST))
        else $error("zero flag does not match result");

endmodule : ptr_logic_exec

/* File: data_file_model.sv */
/* Behavioural data memory file at the far side of the execution block.
   Assumes one clock; read is combinational and forwards a write in flight. */
`timescale 1ns/1ps
module data_file_model
(
    input  wire logic       i_clk,
    input  wire logic [6:0] i_raddr,
    input  wire logic       i_we,
    input  wire logic [6:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [128];

    // Known start pattern, mirrored by the bench
    initial
    begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
    end

    // Write port
    always @(posedge i_clk)
    begin
        if (i_we) mem[i_waddr] <= i_wdata;
    end

    // Bypass so a back-to-back reader sees the pending write
    assign o_rdata = (i_we && i_waddr == i_raddr) ? i_wdata : mem[i_raddr];
endmodule : data_file_model

/* File: tb_ptr_logic_exec.sv */
/* Self-checking bench: decoder driver with expected-result queue, output monitor.
   Assumes the data file model above and the exec_pkg constants. */
`timescale 1ns/1ps
module tb_ptr_logic_exec;
    import exec_pkg::*;
    typedef struct {logic [58:0] v; int n;} note_s;
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, pcw = 1'b0, cnd = 1'b0, ind = 1'b0, sel = 1'b0;
    logic [13:0] ins = 14'h0000;
    logic [7:0]  rdata, acc, wdata, m_acc, l_wd;
    logic [7:0]  mem [128];
    logic [15:0] p0, p1;
    logic [15:0] m_p [2];
    logic [6:0]  waddr, l_wa;
    logic        ready, z, c, nb, we, m_z, m_c, m_nb, ewe;
    logic        took = 1'b0;
    logic [5:0]  ops [5] = '{OPC_AND_IMM, OPC_ADD_IMM, OPC_AND_REG, OPC_ADD_REG, OPC_ASR};
    logic [5:0]  lits [4] = '{6'h20, 6'h1F, 6'h01, 6'h3F};
    note_s       q [$];
    note_s       nt;
    int          err_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          stall_left = 0;

    ptr_logic_exec i_dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_INSTR_VALID(vld),
        .I_INSTR(ins), .I_FILE_RDATA(rdata), .I_PROG_CNT_WRITE(pcw), .I_COND_TRUE(cnd),
        .I_INDIRECT(ind), .I_IND_SEL(sel), .O_READY(ready), .O_ACC(acc),
        .O_FLAG_ZERO(z), .O_FLAG_CARRY(c), .O_FLAG_NIBBLE(nb), .O_PTR0(p0), .O_PTR1(p1),
        .O_FILE_WE(we), .O_FILE_ADDR(waddr), .O_FILE_WDATA(wdata));
    data_file_model i_file (.i_clk(clk), .i_raddr(ins[6:0]), .i_we(we), .i_waddr(waddr),
        .i_wdata(wdata), .o_rdata(rdata));

    always #50 clk = ~clk;

    task chk(input logic [58:0] got, input logic [58:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task tally_and_finish;
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Result into accumulator or file register, zero flag with it
    task put(input logic [7:0] r, input logic d, input logic [6:0] a);
        m_z = (r == 8'h00);
        if (d)
        begin
            mem[a] = r;
            l_wa = a;
            l_wd = r;
            ewe = 1'b1;
        end
        else m_acc = r;
    endtask : put

    task add(input logic [7:0] x, input logic d, input logic [6:0] a);
        logic [8:0] s;
        s = {1'b0, m_acc} + {1'b0, x};
        m_nb = ({1'b0, m_acc[3:0]} + {1'b0, x[3:0]}) > 5'h0F;
        m_c = s[8];
        put(s[7:0], d, a);
    endtask : add

    // Offer one word; while stalled, garbage is held up to be refused
    task issue(input logic [13:0] w, input logic p, input logic cc, input logic i, input logic s);
        logic [7:0] f;
        int n;
        @(negedge clk);
        while (!ready)
        begin
            ins = 14'($urandom);
            vld = 1'b1;
            @(negedge clk);
        end
        f = mem[w[6:0]];
        n = int'(p | cc) + int'(i & m_p[s][15]);
        ewe = 1'b0;
        vld = 1'b1;
        ins = w;
        pcw = p;
        cnd = cc;
        ind = i;
        sel = s;
        if (w[13:7] == OPC7_PTR_ADD) m_p[w[6]] = m_p[w[6]] + {{10{w[5]}}, w[5:0]};
        else
            case (w[13:8])
                OPC_AND_IMM: put(m_acc & w[7:0], 1'b0, l_wa);
                OPC_ADD_IMM: add(w[7:0], 1'b0, l_wa);
                OPC_AND_REG: put(m_acc & f, w[7], w[6:0]);
                OPC_ADD_REG: add(f, w[7], w[6:0]);
                OPC_ASR:
                begin
                    m_c = f[0];
                    put({f[7], f[7:1]}, w[7], w[6:0]);
                end
                default: ;
            endcase
        q.push_back('{{m_acc, m_z, m_c, m_nb, m_p[0], m_p[1], ewe, l_wa, l_wd}, n});
    endtask : issue

    task idle;
        @(negedge clk);
        vld = 1'b0;
    endtask : idle

    task do_reset;
        rst_n = 1'b0;
        q.delete();
        repeat (6) @(negedge clk);
        chk({acc, z, c, nb, p0, p1, we, waddr, wdata}, 59'h0);
        chk(59'(ready), 59'h1);
        rst_n = 1'b1;
        {m_acc, m_z, m_c, m_nb, l_wa, l_wd} = '0;
        m_p[0] = 16'h0000;
        m_p[1] = 16'h0000;
    endtask : do_reset

    // Monitor: compare each taken result, then the idle slots
    always @(posedge clk) took <= rst_n && vld && ready;
    always @(negedge clk)
    begin
        if (!rst_n) stall_left = 0;
        else if (took)
        begin
            nt = q.pop_front();
            chk({acc, z, c, nb, p0, p1, we, waddr, wdata}, nt.v);
            chk(59'(ready), 59'(nt.n == 0));
            stall_left = nt.n;
        end
        else if (stall_left > 0)
        begin
            stall_left--;
            chk(59'(ready), 59'(stall_left == 0));
        end
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            tally_and_finish;
        end
    end

    initial
    begin
        logic [13:0] w;
        int k;
        void'($urandom(71));
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
        do_reset;
        // Pointer pair 1 across both ends of its range, with indirect stretch
        foreach (lits[i]) issue({OPC7_PTR_ADD, 1'b1, lits[i]}, 1'b0, 1'b0, 1'b1, 1'b1);
        foreach (lits[i]) issue({OPC7_PTR_ADD, 1'b1, lits[i]}, 1'b1, 1'b0, 1'b1, 1'b1);
        for (int r = 0; r < 2; r++)
        begin
            repeat (250)
            begin
                k = $urandom_range(0, 6);
                w = 14'($urandom);
                if (k == 0) w[13:7] = OPC7_PTR_ADD;
                else if (k < 6) w[13:8] = ops[k - 1];
                else w[13:8] = 6'h3F;
                issue(w, $urandom_range(0, 3) == 0, $urandom_range(0, 3) == 0,
                      1'($urandom), 1'($urandom));
                if ($urandom_range(0, 3) == 0) idle;
            end
            idle;
            repeat (4) @(negedge clk);
            if (r == 0) do_reset;
        end
        tally_and_finish;
    end
endmodule : tb_ptr_logic_exec
